// ==== common/tccsf_pkg.sv ====
// tccsf_pkg: constants shared by the timer capture/compare status flag block
// assumes: 16-bit timer counters and a 32-bit AXI4-Lite register bus
package tccsf_pkg;

    // counter and register geometry
    localparam int CNT_W = 16;
    localparam int GEN_N = 8;
    localparam int STAT_W = 9;
    localparam int AXI_ADDR_W = 12;
    localparam int AXI_DATA_W = 32;

    // register byte addresses
    localparam logic [11:0] CH1_MAIN_STATUS_OFF = 12'h000;
    localparam logic [11:0] CHAN1_SECONDARY_STATUS_OFF = 12'h004;
    localparam logic [11:0] CHAN2_MAIN_STATUS_OFF = 12'h008;

    // field positions
    localparam int OVF_BIT = 8;
    localparam int CMF_BIT = 0;
    localparam int GEN_LSB = 0;

    // reset value and counter wrap end points
    localparam logic [8:0] STATUS_RESET = 9'h000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;

    // bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tccsf_pkg

// ==== core/tccsf_flag_reg.sv ====
// tccsf_flag_reg: one status register of sticky flags, cleared by
// reading a 1 and then writing 0
// assumes: rd_take/wr_take are single-cycle strobes on ref_clk
`timescale 1ns/1ns
`default_nettype none
module tccsf_flag_reg
    import tccsf_pkg::*;
#(
    parameter int WIDTH = STAT_W
)
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // hardware events
    input wire logic [WIDTH-1:0] set_evt,
    // software access
    input wire logic rd_take,
    input wire logic wr_take,
    input wire logic [WIDTH-1:0] wr_bit_en,
    input wire logic [WIDTH-1:0] wr_data,
    // flag contents
    output logic [WIDTH-1:0] flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flag;
        logic [WIDTH-1:0] armed;
    } tccsf_flag_state_t;

    tccsf_flag_state_t state_reg;
    tccsf_flag_state_t state_next;
    logic [WIDTH-1:0] clr;

    always_comb
    begin
        state_next = state_reg;
        clr = '0;
        // read arms exactly the bits that were returned as 1
        if (rd_take)
        begin
            state_next.armed = state_reg.flag;
        end
        if (wr_take)
        begin
            // written 1s are ignored; a 0 clears only an armed bit
            clr = wr_bit_en & ~wr_data & state_reg.armed;
            state_next.armed = state_reg.armed & ~wr_bit_en;
        end
        // set wins over a clear in the same cycle
        state_next.flag = (state_reg.flag & ~clr) | set_evt;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    assign flags = state_reg.flag;

endmodule : tccsf_flag_reg
`default_nettype wire

// ==== core/tccsf_top.sv ====
// tccsf_top: status flags of timer channels 1 and 2 behind AXI4-Lite
// assumes: counters, general registers, capture strobes and mode bits come
// from timer logic on ref_clk; capture copying itself happens outside
//
// Overview of operation
// - ch1 capture into general register sets flag
// - ch1 counter equals compare register sets flag
// - flag clears after read-1 then write-0
// - writing 1 never sets a flag
// - status bits 15..9 read zero
// - ch1 secondary bits 7..1 read zero
// - ch1 secondary counter wrap sets bit 8
// - ch1 secondary counter equals compare sets bit 0
// - ch2 main counter wrap sets bit 8
// - ch2 capture into general register sets flag
// - ch2 counter equals compare register sets flag
// - ch2 flags H..A in bits 7..0
// - ch1 flag B bit 1, A bit 0
// - ch1 main counter wrap sets overflow flag
// - ch1 flags H..C in bits 7..2
`timescale 1ns/1ns
`default_nettype none
module tccsf_top
    import tccsf_pkg::*;
#(
    parameter int CW = CNT_W,
    parameter int GN = GEN_N
)
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // channel 1 timer state
    input wire logic [CW-1:0] ch1_main_counter,
    input wire logic [CW-1:0] ch1_secondary_counter,
    input wire logic [CW-1:0] ch1_output_compare_reg,
    input wire logic [GN-1:0][CW-1:0] ch1_general_regs,
    input wire logic [GN-1:0] ch1_capture_strobe,
    input wire logic [GN-1:0] ch1_compare_mode,
    // channel 2 timer state
    input wire logic [CW-1:0] ch2_main_counter,
    input wire logic [GN-1:0][CW-1:0] ch2_general_regs,
    input wire logic [GN-1:0] ch2_capture_strobe,
    input wire logic [GN-1:0] ch2_compare_mode,
    // axi4-lite write address
    input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [AXI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // flag levels for the timer's own use
    output logic [STAT_W-1:0] ch1_main_flags,
    output logic [STAT_W-1:0] ch1_secondary_flags,
    output logic [STAT_W-1:0] ch2_main_flags
);

    typedef struct packed {
        logic aw_full;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [AXI_DATA_W-1:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic [CW-1:0] c1m_prev;
        logic [CW-1:0] c1s_prev;
        logic [CW-1:0] c2m_prev;
    } tccsf_top_state_t;

    tccsf_top_state_t state_reg;
    tccsf_top_state_t state_next;

    // event vectors per status register
    logic [STAT_W-1:0] c1m_set;
    logic [STAT_W-1:0] c1s_set;
    logic [STAT_W-1:0] c2m_set;
    logic [GN-1:0] c1_gen_evt;
    logic [GN-1:0] c2_gen_evt;

    // bus strobes towards the flag registers
    logic ar_take;
    logic wr_commit;
    logic [2:0] rd_sel;
    logic [2:0] wr_sel;
    logic [STAT_W-1:0] wr_bit_en;
    logic [STAT_W-1:0] wr_bits;

    // a compare hit counts once, when the counter steps onto the value;
    // a stalled counter would otherwise re-set the flag every cycle
    genvar gi;
    generate
        for (gi = 0; gi < GN; gi++)
        begin : g_gen
            assign c1_gen_evt[gi] = ch1_compare_mode[gi]
                ? (ch1_main_counter == ch1_general_regs[gi]
                   && ch1_main_counter != state_reg.c1m_prev)
                : ch1_capture_strobe[gi];
            assign c2_gen_evt[gi] = ch2_compare_mode[gi]
                ? (ch2_main_counter == ch2_general_regs[gi]
                   && ch2_main_counter != state_reg.c2m_prev)
                : ch2_capture_strobe[gi];
        end
    endgenerate

    always_comb
    begin
        c1m_set = STATUS_RESET;
        c1m_set[GEN_LSB +: GEN_N] = c1_gen_evt;
        c1m_set[OVF_BIT] = state_reg.c1m_prev == CNT_MAX
            && ch1_main_counter == CNT_ZERO;
        // secondary bits 7..1 get no event and so stay at zero
        c1s_set = STATUS_RESET;
        c1s_set[OVF_BIT] = state_reg.c1s_prev == CNT_MAX
            && ch1_secondary_counter == CNT_ZERO;
        c1s_set[CMF_BIT] = ch1_secondary_counter == ch1_output_compare_reg
            && ch1_secondary_counter != state_reg.c1s_prev;
        c2m_set = STATUS_RESET;
        c2m_set[GEN_LSB +: GEN_N] = c2_gen_evt;
        c2m_set[OVF_BIT] = state_reg.c2m_prev == CNT_MAX
            && ch2_main_counter == CNT_ZERO;
    end

    // bus handshakes; readies drop with ce so no beat is taken and lost
    assign s_axi_awready = ce && !state_reg.aw_full && !state_reg.bvalid;
    assign s_axi_wready = ce && !state_reg.w_full && !state_reg.bvalid;
    assign s_axi_arready = ce && !state_reg.rvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready && ce;
    assign wr_commit = state_reg.aw_full && state_reg.w_full
        && !state_reg.bvalid && ce;

    always_comb
    begin
        rd_sel = 3'h0;
        if (ar_take)
        begin
            rd_sel[0] = s_axi_araddr == CH1_MAIN_STATUS_OFF;
            rd_sel[1] = s_axi_araddr == CHAN1_SECONDARY_STATUS_OFF;
            rd_sel[2] = s_axi_araddr == CHAN2_MAIN_STATUS_OFF;
        end
        wr_sel = 3'h0;
        if (wr_commit)
        begin
            wr_sel[0] = state_reg.aw_addr == CH1_MAIN_STATUS_OFF;
            wr_sel[1] = state_reg.aw_addr == CHAN1_SECONDARY_STATUS_OFF;
            wr_sel[2] = state_reg.aw_addr == CHAN2_MAIN_STATUS_OFF;
        end
        // byte lane 0 covers bits 7..0, lane 1 covers bit 8
        wr_bit_en = {state_reg.w_strb[1], {GEN_N{state_reg.w_strb[0]}}};
        wr_bits = state_reg.w_data[STAT_W-1:0];
    end

    always_comb
    begin
        state_next = state_reg;
        state_next.c1m_prev = ch1_main_counter;
        state_next.c1s_prev = ch1_secondary_counter;
        state_next.c2m_prev = ch2_main_counter;
        // write address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            state_next.aw_full = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            state_next.w_full = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (wr_commit)
        begin
            state_next.aw_full = 1'b0;
            state_next.w_full = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = (wr_sel == 3'h0) ? RESP_SLVERR : RESP_OKAY;
        end
        if (state_reg.bvalid && s_axi_bready)
        begin
            state_next.bvalid = 1'b0;
        end
        if (ar_take)
        begin
            state_next.rvalid = 1'b1;
            state_next.rresp = RESP_OKAY;
            // upper reserved bits come back as zero
            unique case (1'b1)
                rd_sel[0]:
                    state_next.rdata = {23'h000000, ch1_main_flags};
                rd_sel[1]:
                    state_next.rdata = {23'h000000, ch1_secondary_flags};
                rd_sel[2]:
                    state_next.rdata = {23'h000000, ch2_main_flags};
                default:
                begin
                    state_next.rdata = '0;
                    state_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        else if (state_reg.rvalid && s_axi_rready)
        begin
            state_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_reg <= '0;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;

    // one flag register per status word
    tccsf_flag_reg #(
        .WIDTH(STAT_W)
    ) u_ch1_main (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .set_evt(c1m_set),
        .rd_take(rd_sel[0]),
        .wr_take(wr_sel[0]),
        .wr_bit_en(wr_bit_en),
        .wr_data(wr_bits),
        .flags(ch1_main_flags)
    );

    tccsf_flag_reg #(
        .WIDTH(STAT_W)
    ) u_ch1_secondary (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .set_evt(c1s_set),
        .rd_take(rd_sel[1]),
        .wr_take(wr_sel[1]),
        .wr_bit_en(wr_bit_en),
        .wr_data(wr_bits),
        .flags(ch1_secondary_flags)
    );

    tccsf_flag_reg #(
        .WIDTH(STAT_W)
    ) u_ch2_main (
        .ref_clk(ref_clk),
        .rst(rst),
        .ce(ce),
        .set_evt(c2m_set),
        .rd_take(rd_sel[2]),
        .wr_take(wr_sel[2]),
        .wr_bit_en(wr_bit_en),
        .wr_data(wr_bits),
        .flags(ch2_main_flags)
    );

endmodule : tccsf_top
`default_nettype wire

// ==== verification/tccsf_assertions.sv ====
// tccsf_assertions: flag and bus relations on tccsf_top ports
// assumes: bound to tccsf_top; checks pause in reset and while ce is low
`timescale 1ns/1ns
`default_nettype none
module tccsf_assertions
    import tccsf_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic ce,
    // timer state
    input wire logic [15:0] ch1_secondary_counter,
    input wire logic [15:0] ch1_output_compare_reg,
    input wire logic [15:0] ch2_main_counter,
    input wire logic [7:0] ch1_capture_strobe,
    input wire logic [7:0] ch1_compare_mode,
    input wire logic [7:0] ch2_capture_strobe,
    input wire logic [7:0] ch2_compare_mode,
    // bus and flags
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic [8:0] ch1_main_flags,
    input wire logic [8:0] ch1_secondary_flags,
    input wire logic [8:0] ch2_main_flags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst || !ce);
    wire logic [7:0] cap1 = ch1_capture_strobe & ~ch1_compare_mode;
    wire logic [7:0] cap2 = ch2_capture_strobe & ~ch2_compare_mode;
    a_cap_ch1: assert property (cap1 != 8'h00 |=>
        (ch1_main_flags[7:0] & $past(cap1)) == $past(cap1)) else $error("ch1 capture");
    a_cap_ch2: assert property (cap2 != 8'h00 |=>
        (ch2_main_flags[7:0] & $past(cap2)) == $past(cap2)) else $error("ch2 capture");
    a_wrap_ch1b: assert property (!$past(rst) &&
        $past(ch1_secondary_counter) == 16'hFFFF &&
        ch1_secondary_counter == 16'h0000 |=> ch1_secondary_flags[8])
        else $error("ch1 secondary wrap");
    a_wrap_ch2: assert property (!$past(rst) &&
        $past(ch2_main_counter) == 16'hFFFF && ch2_main_counter == 16'h0000
        |=> ch2_main_flags[8]) else $error("ch2 wrap");
    a_cmp_ch1b: assert property (!$past(rst) &&
        $changed(ch1_secondary_counter) &&
        ch1_secondary_counter == ch1_output_compare_reg
        |=> ch1_secondary_flags[0]) else $error("ch1 compare");
    // a ch2 main flag may only drop together with a write response
    a_sticky_flag: assert property (!$past(rst) &&
        ($past(ch2_main_flags) & ~ch2_main_flags) != 9'h000
        |-> $rose(s_axi_bvalid)) else $error("flag dropped");
    a_sec_resv: assert property (ch1_secondary_flags[7:1] == 7'h00)
        else $error("secondary reserved set");
    a_resv_read: assert property (s_axi_rvalid |->
        s_axi_rdata[31:9] == 23'h000000) else $error("reserved read");
    cover property (cap2 != 8'h00);
    cover property ($rose(s_axi_bvalid));
    cover property ($fell(ch2_main_flags[8]));
endmodule : tccsf_assertions
bind tccsf_top tccsf_assertions tccsf_assertions_inst (
    .ref_clk(ref_clk), .rst(rst), .ce(ce),
    .ch1_secondary_counter(ch1_secondary_counter),
    .ch1_output_compare_reg(ch1_output_compare_reg),
    .ch2_main_counter(ch2_main_counter),
    .ch1_capture_strobe(ch1_capture_strobe),
    .ch1_compare_mode(ch1_compare_mode),
    .ch2_capture_strobe(ch2_capture_strobe),
    .ch2_compare_mode(ch2_compare_mode),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_bvalid(s_axi_bvalid), .ch1_main_flags(ch1_main_flags),
    .ch1_secondary_flags(ch1_secondary_flags),
    .ch2_main_flags(ch2_main_flags));
`default_nettype wire

// ==== verification/tccsf_top_tb_top.sv ====
// tccsf_top_tb_top: table-driven flag bench for tccsf_top
// assumes: one bus transfer at a time; ce drops only in its own test
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %h want %h", $time, g, e); end end
module tccsf_top_tb_top
    import tccsf_pkg::*;
();
    typedef struct {int s; int b; logic cap; logic [31:0] exp;} tccsf_row_t;
    tccsf_row_t rows[20];
    logic ref_clk = 0, rst = 1, ce = 1;
    logic [15:0] c1m = 0, c1s = 0, ocr = 16'h1234, c2m = 0;
    logic [7:0][15:0] gr;
    logic [7:0] st1 = 0, md1 = 0, st2 = 0, md2 = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [3:0] wstrb = 4'hF;
    logic [31:0] wdata = 0, rdata, rd;
    logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wr, bv, arr, rv;
    logic [1:0] br, rr, resp;
    logic [8:0] f1m, f1s, f2m;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    tccsf_top tccsf_top_inst (.ref_clk(ref_clk), .rst(rst), .ce(ce),
        .ch1_main_counter(c1m), .ch1_secondary_counter(c1s),
        .ch1_output_compare_reg(ocr), .ch1_general_regs(gr),
        .ch1_capture_strobe(st1), .ch1_compare_mode(md1),
        .ch2_main_counter(c2m), .ch2_general_regs(gr),
        .ch2_capture_strobe(st2), .ch2_compare_mode(md2),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
        .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .ch1_main_flags(f1m),
        .ch1_secondary_flags(f1s), .ch2_main_flags(f2m));
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            complete_run();
        end
    end
    // handshakes read at negedge so combinational readies are settled
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic ad = 0, wd = 0, bd = 0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1;
        wv <= 1;
        bre <= 1;
        while (!(ad && wd))
        begin
            @(negedge ref_clk);
            ad = ad || (awv && awr);
            wd = wd || (wv && wr);
            @(posedge ref_clk);
            if (ad) awv <= 0;
            if (wd) wv <= 0;
        end
        while (!bd)
        begin
            @(negedge ref_clk);
            bd = bv;
            resp = br;
            @(posedge ref_clk);
        end
        bre <= 0;
    endtask : axw
    task automatic axr(input logic [11:0] a);
        logic at = 0, dn = 0;
        @(posedge ref_clk);
        araddr <= a;
        arv <= 1;
        rre <= 1;
        while (!dn)
        begin
            @(negedge ref_clk);
            at = arv && arr;
            dn = rv;
            rd = rdata;
            resp = rr;
            @(posedge ref_clk);
            if (at) arv <= 0;
        end
        rre <= 0;
    endtask : axr
    task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
        axr(a);
        `CHK(rd, e)
        `CHK(resp, RESP_OKAY)
    endtask : chk_reg
    task automatic wrap(input int s, input logic [15:0] v);
        case (s)
            0: c1m <= v;
            1: c1s <= v;
            default: c2m <= v;
        endcase
    endtask : wrap
    task automatic fire(input int s, input int b, input logic cap);
        @(posedge ref_clk);
        if (b == 8)
        begin
            wrap(s, 16'hFFFF);
            @(posedge ref_clk);
            wrap(s, 16'h0000);
        end
        else if (s == 1)
            c1s <= ocr;
        else if (cap)
        begin
            if (s == 0) st1[b] <= 1;
            else st2[b] <= 1;
            @(posedge ref_clk);
            st1 <= 0;
            st2 <= 0;
        end
        else
        begin
            if (s == 0) md1[b] <= 1;
            else md2[b] <= 1;
            @(posedge ref_clk);
            wrap(s, gr[b]);
            @(posedge ref_clk);
            md1 <= 0;
            md2 <= 0;
        end
    endtask : fire
    function automatic logic [11:0] off(input int s);
        return s == 0 ? CH1_MAIN_STATUS_OFF : (s == 1 ?
            CHAN1_SECONDARY_STATUS_OFF : CHAN2_MAIN_STATUS_OFF);
    endfunction : off
    function automatic logic [8:0] fl(input int s);
        return s == 0 ? f1m : (s == 1 ? f1s : f2m);
    endfunction : fl
    task automatic settle(input int s, input int b, input logic cap);
        fire(s, b, cap);
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : settle
    initial
    begin
        for (int i = 0; i < 8; i++)
            gr[i] = 16'h1000 + 16'(i) * 16'h0111;
        for (int i = 0; i < 9; i++)
        begin
            rows[i] = '{0, i, i[0], 32'h1 << i};
            rows[i + 9] = '{2, i, !i[0], 32'h1 << i};
        end
        rows[18] = '{1, 0, 0, 32'h1};
        rows[19] = '{1, 8, 0, 32'h100};
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        foreach (rows[k])
        begin
            settle(rows[k].s, rows[k].b, rows[k].cap);
            `CHK(fl(rows[k].s), rows[k].exp[8:0])
            chk_reg(off(rows[k].s), rows[k].exp);
            axw(off(rows[k].s), 32'h0);
            `CHK(resp, RESP_OKAY)
            chk_reg(off(rows[k].s), 32'h0);
        end
        $display("table done");
        settle(2, 8, 0);
        axw(CHAN2_MAIN_STATUS_OFF, 32'h0);
        chk_reg(CHAN2_MAIN_STATUS_OFF, 32'h100);
        axw(CHAN2_MAIN_STATUS_OFF, 32'h0);
        $display("lone zero write done");
        settle(2, 0, 1);
        settle(2, 8, 0);
        chk_reg(CHAN2_MAIN_STATUS_OFF, 32'h101);
        wstrb <= 4'h1;
        // capture on bit 0 lands in the clearing write's commit cycle
        fork
            axw(CHAN2_MAIN_STATUS_OFF, 32'h0);
            begin
                repeat (2) @(posedge ref_clk);
                st2[0] <= 1;
                @(posedge ref_clk);
                st2 <= 0;
            end
        join
        wstrb <= 4'hF;
        #1;
        `CHK(f2m, 9'h101)
        axw(CHAN2_MAIN_STATUS_OFF, 32'h0);
        chk_reg(CHAN2_MAIN_STATUS_OFF, 32'h001);
        axw(CHAN2_MAIN_STATUS_OFF, 32'h0);
        $display("byte lane and set over clear done");
        for (int s = 0; s < 3; s++)
        begin
            chk_reg(off(s), 32'h0);
            axw(off(s), s == 1 ? 32'h101 : 32'h1FF);
            chk_reg(off(s), 32'h0);
        end
        $display("write ones done");
        @(posedge ref_clk);
        ce <= 0;
        st2[0] <= 1;
        @(posedge ref_clk);
        st2 <= 0;
        @(posedge ref_clk);
        ce <= 1;
        #1;
        `CHK(f2m, 9'h000)
        $display("clock enable done");
        axr(12'h00C);
        `CHK(resp, RESP_SLVERR)
        `CHK(rd, 32'h0)
        axw(12'h00C, 32'h0);
        `CHK(resp, RESP_SLVERR)
        $display("unmapped done");
        settle(0, 1, 1);
        `CHK(f1m, 9'h002)
        @(posedge ref_clk);
        rst <= 1;
        repeat (3) @(posedge ref_clk);
        rst <= 0;
        #1;
        `CHK(f1m, STATUS_RESET)
        chk_reg(CH1_MAIN_STATUS_OFF, 32'h0);
        $display("mid reset done");
        complete_run();
    end
endmodule : tccsf_top_tb_top
`default_nettype wire
